// ### logic/rail_seq_pkg.sv
package rail_seq_pkg;

  // ****************************************************************
  // Channel counts and widths
  // ****************************************************************
  localparam int NUM_RAILS = 8;
  localparam int NUM_GPOS  = 4;
  localparam int NUM_LOG   = NUM_RAILS + NUM_GPOS;   // Logical channels: rails 0..7, outputs 8..11
  localparam int NUM_PHYS  = NUM_LOG - 1;            // Rail 8 and output 1 share one pin
  localparam int SHARED_CH = 7;                      // Physical index of the shared pin
  localparam int GPO_BASE  = NUM_RAILS;              // Logical index of the first general output
  localparam int DELAY_W   = 16;                     // Width in bits of each shutdown delay, counted in ticks
  localparam int STRAP_W   = 4;
  localparam int ADDR_W    = 7;

  // ****************************************************************
  // Timing: one delay tick is one millisecond
  // ****************************************************************
  localparam int CLK_MHZ      = 200;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES  = TICK_TIME_US * CLK_MHZ;
  localparam int TICK_W       = 18;

  // ****************************************************************
  // Restart register and its command codes
  // ****************************************************************
  localparam logic [7:0] RESTART_REG  = 8'h2f;
  localparam logic [7:0] CMD_SEQUENCE = 8'h00;
  localparam logic [7:0] CMD_SHUTDOWN = 8'hc0;

  // Upper target address bits above the straps; value is arbitrary
  localparam logic [ADDR_W-STRAP_W-1:0] ADDR_BASE = 3'h5;

  // ****************************************************************
  // Sequencer states, Gray coded along boot, run, idle
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_RUN  = 2'b01,
    ST_IDLE = 2'b11,
    ST_HOLD = 2'b10
  } seq_state_t;

endpackage

// ### logic/shutdown_timer.sv
`timescale 1ns/1ps
`default_nettype none
module shutdown_timer
  import rail_seq_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  input  wire logic               tick,
  input  wire logic               turnOn,
  input  wire logic               markOff,
  input  wire logic [DELAY_W-1:0] delay,
  output logic                    enableOut_r
);

  logic               counting_r;
  logic [DELAY_W-1:0] count_r;

  // ****************************************************************
  // Per-channel delay, free of every other channel
  // ****************************************************************
  // The first marking event sets the start; later ones are ignored so the delay stays measured from it
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      enableOut_r <= 1'b0;
      counting_r  <= 1'b0;
      count_r     <= '0;
    end
    else if (turnOn)
    begin
      enableOut_r <= 1'b1;
      counting_r  <= 1'b0;
    end
    else if (markOff && enableOut_r && !counting_r)
    begin
      count_r <= delay;
      if (delay == '0)
        enableOut_r <= 1'b0;                      // Zero delay turns off at once
      else
        counting_r <= 1'b1;
    end
    else if (counting_r && tick)
    begin
      if (count_r == DELAY_W'(1))
      begin
        enableOut_r <= 1'b0;
        counting_r  <= 1'b0;
      end
      count_r <= count_r - DELAY_W'(1);
    end
  end

endmodule // shutdown_timer
`default_nettype wire

// ### logic/strap_capture.sv
`timescale 1ns/1ps
`default_nettype none
module strap_capture
  import rail_seq_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  input  wire logic [STRAP_W-1:0] straps,
  output logic [ADDR_W-1:0]       targetAddr_r,
  output logic                    captured_r
);

  // ****************************************************************
  // Strap sampling at power-up
  // ****************************************************************
  // Reset only loads constants; the strap levels are taken at the first edge after release
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      targetAddr_r <= '0;
      captured_r   <= 1'b0;
    end
    else if (!captured_r)
    begin
      targetAddr_r <= {ADDR_BASE, straps};
      captured_r   <= 1'b1;
    end
  end

endmodule // strap_capture
`default_nettype wire

// ### logic/rail_shutdown_sequencer_config.sv
// Behaviour
// - Each of eight rails and four outputs has its own shutdown delay.
// - A channel marked for shutdown turns off after its own delay.
// - Dependent rail delay runs from the marking event to its enable going low.
// - Dependents start timing when a forced parent falls under its undervoltage threshold.
// - A setting selects internal or supply voltage as converter reference.
// - Shared pin is rail eight enable or output one; other function ignored.
// - Sequence control clear and error log occupied: stay held in reset.
// - Sequence control set: start up whatever the error log holds.
// - Target address comes from four straps sampled at power-up.
// - Factory default parameters: no sequencing at start-up.
// - Sequence code written to restart register runs start-up sequence.
// - Shutdown code to restart register turns everything off with delays.
`timescale 1ns/1ps
`default_nettype none
module rail_shutdown_sequencer_config
  import rail_seq_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
)
(
  input  wire logic                                sys_clk,
  input  wire logic                                rstn,
  // Configuration
  input  wire logic [NUM_RAILS-1:0][DELAY_W-1:0]   railShutdownDelay,
  input  wire logic [NUM_GPOS-1:0][DELAY_W-1:0]    gpoShutdownDelay,
  input  wire logic [NUM_RAILS-1:0][NUM_LOG-1:0]   dependentMask,
  input  wire logic [NUM_LOG-1:0]                  sequenceMask,
  input  wire logic                                adcRefSelect,
  input  wire logic                                pinFuncGpo,
  input  wire logic                                sequenceControl,
  input  wire logic                                factoryDefault,
  input  wire logic                                errorLogEntries,
  // Rail monitoring
  input  wire logic [NUM_RAILS-1:0]                railForceOff,
  input  wire logic [NUM_RAILS-1:0]                undervoltageThreshold,
  // Restart register write
  input  wire logic                                restartWrite,
  input  wire logic [7:0]                          restartAddr,
  input  wire logic [7:0]                          restartData,
  // Straps
  input  wire logic                                address_strap_a,
  input  wire logic                                address_strap_b,
  input  wire logic                                address_strap_c,
  input  wire logic                                address_strap_d,
  // Outputs
  output logic [SHARED_CH-1:0]                     rail_enable_out,
  output logic                                     rail8_enable_out,
  output logic [NUM_GPOS-2:0]                      general_purpose_output,
  output logic [ADDR_W-1:0]                        targetAddr,
  output logic                                     adcRefExternal_r,
  output logic                                     heldInReset_r,
  output logic                                     sequenceRunning_r
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  seq_state_t                        state_r;
  seq_state_t                        state_nxt;
  logic [TICK_W-1:0]                 tickCnt_r;
  logic                              tick_r;
  logic                              startPulse_r;
  logic                              shutdownPulse_r;
  logic [NUM_RAILS-1:0]              railForced_r;
  logic [NUM_LOG-1:0]                logMark;
  logic [NUM_LOG-1:0]                logOn;
  logic [NUM_RAILS-1:0]              railValid;
  logic [NUM_PHYS-1:0]               physOn;
  logic [NUM_PHYS-1:0]               physMark;
  logic [NUM_PHYS-1:0][DELAY_W-1:0]  physDelay;
  logic [NUM_PHYS-1:0]               physEnable;
  logic                              cmdSequence;
  logic                              cmdShutdown;
  logic                              holdCond;
  logic                              strapsDone;

  // ****************************************************************
  // Millisecond tick divider
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tickCnt_r <= '0;
      tick_r    <= 1'b0;
    end
    // One enable pulse per delay tick drives every channel timer, so all delays share one time base
    // Limitation: a channel marked just before a tick drops up to one tick sooner than its setting
    // TICK_COUNT is a parameter only so that checks can run with a short tick
    // The pulse is registered, so every timer sees it on the same edge
    else if (tickCnt_r == TICK_W'(TICK_COUNT - 1))
    begin
      tickCnt_r <= '0;
      tick_r    <= 1'b1;
    end
    else
    begin
      tickCnt_r <= tickCnt_r + TICK_W'(1);
      tick_r    <= 1'b0;
    end
  end

  // ****************************************************************
  // Restart register decode
  // ****************************************************************
  // Writes to any other register, or other codes, fall through and change nothing
  // A command acts on its strobe cycle; there is no queue, so back-to-back writes each act
  assign cmdSequence = restartWrite && (restartAddr == RESTART_REG) && (restartData == CMD_SEQUENCE);
  assign cmdShutdown = restartWrite && (restartAddr == RESTART_REG) && (restartData == CMD_SHUTDOWN);

  // Start-up is held only when the log is occupied and sequence control is clear
  assign holdCond = errorLogEntries && !sequenceControl;

  // ****************************************************************
  // Start-up and shutdown state machine
  // ****************************************************************
  always_comb
  begin
    // BOOT waits for the strap capture so the address is fixed before anything runs
    // HOLD stands in for the device kept in reset; it leaves by itself once the hold condition drops
    // The factory-default check is made only at boot; a later sequence command ignores it and runs, or goes to HOLD under the hold condition
    state_nxt = state_r;
    unique case (state_r)
      ST_BOOT:
      begin
        if (strapsDone)
        begin
          if (factoryDefault)
            state_nxt = ST_IDLE;
          else if (holdCond)
            state_nxt = ST_HOLD;
          else
            state_nxt = ST_RUN;
        end
      end
      ST_HOLD:
      begin
        if (!holdCond)
          state_nxt = ST_RUN;
      end
      ST_RUN:
      begin
        if (cmdShutdown)
          state_nxt = ST_IDLE;
        else if (cmdSequence && holdCond)
          state_nxt = ST_HOLD;
      end
      ST_IDLE:
      begin
        if (cmdSequence)
          state_nxt = holdCond ? ST_HOLD : ST_RUN;
      end
    endcase
  end

  // State register and status flags
  // Flags follow the next state so they line up with state_r rather than lag it by one edge
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r           <= ST_BOOT;
      heldInReset_r     <= 1'b0;
      sequenceRunning_r <= 1'b0;
    end
    else
    begin
      state_r           <= state_nxt;
      heldInReset_r     <= (state_nxt == ST_HOLD);
      sequenceRunning_r <= (state_nxt == ST_RUN);
    end
  end

  // One-cycle start and shutdown strobes; a repeated sequence command restarts too
  // Registered so the timers see a clean single-cycle request one edge after the command
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      startPulse_r    <= 1'b0;
      shutdownPulse_r <= 1'b0;
    end
    else
    begin
      startPulse_r    <= (state_nxt == ST_RUN) && ((state_r != ST_RUN) || cmdSequence);
      shutdownPulse_r <= cmdShutdown;
    end
  end

  // ****************************************************************
  // Reference select
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    // Only the choice is kept here; the converter itself sits outside this block
    // Changing the reference rescales every reading, so thresholds must be reviewed with it
    if (!rstn)
      adcRefExternal_r <= 1'b0;
    else
      adcRefExternal_r <= adcRefSelect;
  end

  // ****************************************************************
  // Dependency cascade
  // ****************************************************************
  // Rail 8 does not exist while its pin is a general output, so it can neither force nor be forced
  // Its threshold input is ignored then as well, since the pin no longer feeds a supply
  assign railValid = {!pinFuncGpo, {(NUM_RAILS-1){1'b1}}};

  // A forced parent marks dependents only once it reads under its threshold
  // A parent still above its threshold has not yet dropped, so its dependents keep running
  // Dependents are marked on every cycle the condition holds; the timers act on the first only
  always_comb
  begin
    logMark = '0;
    for (int r = 0; r < NUM_RAILS; r++)
    begin
      if (railForced_r[r] && undervoltageThreshold[r] && railValid[r])
        logMark = logMark | dependentMask[r];
    end
    logMark[NUM_RAILS-1:0] = logMark[NUM_RAILS-1:0] | (railForceOff & railValid);
    if (shutdownPulse_r)
      logMark = '1;
  end

  // A rail marked through a parent becomes a parent itself, so cascades continue downward
  // The start strobe outranks a mark in the same cycle: every rail in the sequence mask is switched back on then,
  // and a stale mark would cut it again at once
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      railForced_r <= '0;
    else if (startPulse_r)
      railForced_r <= '0;
    else
      railForced_r <= railForced_r | (logMark[NUM_RAILS-1:0] & railValid);
  end

  // Start-up timing is not modelled: every channel in the mask turns on with the strobe
  assign logOn = startPulse_r ? sequenceMask : '0;

  // ****************************************************************
  // Logical to physical channel map and timers
  // ****************************************************************
  // Logical channels keep a fixed numbering; only the shared pin switches between two of them
  // Each physical pin owns one timer, so all delays run side by side
  // A timer that is counting ignores marks, so a channel never restarts its own delay
  genvar p;
  generate
    for (p = 0; p < NUM_PHYS; p++)
    begin : g_chan
      if (p < SHARED_CH)
      begin : g_rail
        assign physDelay[p] = railShutdownDelay[p];
        assign physMark[p]  = logMark[p];
        assign physOn[p]    = logOn[p];
      end
      else if (p == SHARED_CH)
      begin : g_shared
        // Only the selected function's settings reach the shared pin
        assign physDelay[p] = pinFuncGpo ? gpoShutdownDelay[0] : railShutdownDelay[NUM_RAILS-1];
        assign physMark[p]  = pinFuncGpo ? logMark[GPO_BASE] : logMark[NUM_RAILS-1];
        assign physOn[p]    = pinFuncGpo ? logOn[GPO_BASE] : logOn[NUM_RAILS-1];
      end
      else
      begin : g_gpo
        assign physDelay[p] = gpoShutdownDelay[p-SHARED_CH];
        assign physMark[p]  = logMark[p+1];
        assign physOn[p]    = logOn[p+1];
      end

      shutdown_timer u_timer (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .tick        (tick_r),
        .turnOn      (physOn[p]),
        .markOff     (physMark[p]),
        .delay       (physDelay[p]),
        .enableOut_r (physEnable[p])
      );
    end
  endgenerate

  // Outputs come straight from the timer flops, so no gate sits between a flop and a pin
  assign rail_enable_out        = physEnable[SHARED_CH-1:0];
  assign rail8_enable_out       = physEnable[SHARED_CH];
  assign general_purpose_output = physEnable[NUM_PHYS-1:SHARED_CH+1];

  // ****************************************************************
  // Target address from straps
  // ****************************************************************
  // Straps are read once; moving them later does not change the address until the next reset
  strap_capture u_straps (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .straps       ({address_strap_d, address_strap_c, address_strap_b, address_strap_a}),
    .targetAddr_r (targetAddr),
    .captured_r   (strapsDone)
  );

endmodule // rail_shutdown_sequencer_config
`default_nettype wire

// ### tb/rail_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rail_seq_sva
  import rail_seq_pkg::*;
(
  input wire logic                              sys_clk,
  input wire logic                              rstn,
  input wire logic                              restartWrite,
  input wire logic [7:0]                        restartAddr,
  input wire logic [7:0]                        restartData,
  input wire logic [NUM_RAILS-1:0][DELAY_W-1:0] railShutdownDelay,
  input wire logic [NUM_LOG-1:0]                sequenceMask,
  input wire logic                              adcRefSelect,
  input wire logic                              sequenceControl,
  input wire logic                              errorLogEntries,
  input wire logic [SHARED_CH-1:0]              rail_enable_out,
  input wire logic [ADDR_W-1:0]                 targetAddr,
  input wire logic                              adcRefExternal_r,
  input wire logic                              heldInReset_r,
  input wire logic                              sequenceRunning_r
);
  // ****************************************************************
  // Command decode and delay classes
  // ****************************************************************
  logic                 seqW;
  logic                 shutW;
  logic [SHARED_CH-1:0] zeroDly;
  logic [SHARED_CH-1:0] longDly;
  assign seqW = restartWrite && restartAddr == RESTART_REG && restartData == CMD_SEQUENCE;
  assign shutW = restartWrite && restartAddr == RESTART_REG && restartData == CMD_SHUTDOWN;
  // Two or more ticks cannot expire before the second edge after the command
  always_comb
  begin
    for (int i = 0; i < SHARED_CH; i++)
    begin
      zeroDly[i] = railShutdownDelay[i] == '0;
      longDly[i] = railShutdownDelay[i] > 16'h0001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence shut_settled;
    shutW ##1 !seqW [*2];
  endsequence
  // ****************************************************************
  // Properties
  // ****************************************************************
  adc_ref_copy_a: assert property ($changed(adcRefSelect) |=> adcRefExternal_r == $past(adcRefSelect))
    else $error("reference select not followed");
  addr_base_a: assert property (targetAddr != '0 |-> targetAddr[ADDR_W-1:STRAP_W] == ADDR_BASE)
    else $error("address upper bits wrong");
  addr_stable_a: assert property (targetAddr != '0 |=> $stable(targetAddr))
    else $error("address changed after capture");
  hold_entry_a: assert property (seqW && errorLogEntries && !sequenceControl |=> heldInReset_r)
    else $error("sequence ran with log entries");
  hold_excl_a: assert property (heldInReset_r |-> !sequenceRunning_r)
    else $error("running while held");
  hold_exit_a: assert property (heldInReset_r && sequenceControl |-> ##[1:2] !heldInReset_r)
    else $error("hold kept despite sequence control");
  seq_run_a: assert property (seqW && !(errorLogEntries && !sequenceControl) |=> sequenceRunning_r
    ##1 (rail_enable_out & sequenceMask[SHARED_CH-1:0]) == sequenceMask[SHARED_CH-1:0])
    else $error("sequence command did not enable rails");
  enable_rise_a: assert property ((rail_enable_out & ~$past(rail_enable_out)) != '0
    |-> $past(sequenceRunning_r))
    else $error("enable rose outside a sequence");
  shut_zero_a: assert property (shut_settled |-> (rail_enable_out & zeroDly) == '0)
    else $error("zero delay rail still on");
  shut_wait_a: assert property (shut_settled
    |-> (rail_enable_out & longDly) == ($past(rail_enable_out, 2) & longDly))
    else $error("rail dropped before its delay");
endmodule // rail_seq_sva
`default_nettype wire

// ### tb/rail_supply_model.sv
`timescale 1ns/1ps
`default_nettype none
module rail_supply_model #(
  parameter int LAG = 3
)
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [7:0] railOn,
  output logic      [7:0] underVolt
);
  logic [7:0][LAG-1:0] hist_r;
  // Supplies ramp and decay with a fixed lag; a rail reads low until it has settled
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      hist_r <= '0;
    else
      for (int i = 0; i < 8; i++)
        hist_r[i] <= {hist_r[i][LAG-2:0], railOn[i]};
  end
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      underVolt[i] = ~hist_r[i][LAG-1];
  end
endmodule // rail_supply_model
`default_nettype wire

// ### tb/rail_shutdown_sequencer_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rail_shutdown_sequencer_config_tb;
  import rail_seq_pkg::*;
  localparam int TICKS = 4;
  logic                              sys_clk, rstn, restartWrite, rail8En;
  logic [NUM_RAILS-1:0][DELAY_W-1:0] railShutdownDelay;
  logic [NUM_GPOS-1:0][DELAY_W-1:0]  gpoShutdownDelay;
  logic [NUM_RAILS-1:0][NUM_LOG-1:0] dependentMask;
  logic [NUM_LOG-1:0]                sequenceMask;
  logic                              adcRefSelect, pinFuncGpo, sequenceControl, factoryDefault, errorLogEntries;
  logic [NUM_RAILS-1:0]              railForceOff, underVolt;
  logic [7:0]                        restartAddr, restartData;
  logic [STRAP_W-1:0]                straps;
  logic [SHARED_CH-1:0]              railEn;
  logic [NUM_GPOS-2:0]               gpoOut;
  logic [ADDR_W-1:0]                 targetAddr;
  logic                              adcRefExternal_r, heldInReset_r, sequenceRunning_r;
  int                                fails, tests_run, n;
  int                                expD [11] = '{0, 1, 2, 3, 4, 5, 6, 7, 2, 3, 4};

  rail_shutdown_sequencer_config #(.TICK_COUNT(TICKS)) u_dut (.sys_clk, .rstn, .railShutdownDelay,
    .gpoShutdownDelay, .dependentMask, .sequenceMask, .adcRefSelect, .pinFuncGpo, .sequenceControl,
    .factoryDefault, .errorLogEntries, .railForceOff, .undervoltageThreshold(underVolt), .restartWrite,
    .restartAddr, .restartData, .address_strap_a(straps[0]), .address_strap_b(straps[1]),
    .address_strap_c(straps[2]), .address_strap_d(straps[3]), .rail_enable_out(railEn),
    .rail8_enable_out(rail8En), .general_purpose_output(gpoOut), .targetAddr, .adcRefExternal_r,
    .heldInReset_r, .sequenceRunning_r);
  rail_supply_model #(.LAG(3)) u_supply (.sys_clk, .rstn, .railOn({rail8En, railEn}), .underVolt);

  // ****************************************************************
  // Clock, watchdog and checking tasks
  // ****************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // The whole sequence needs well under 400 cycles
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end
  task automatic step(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task automatic check_bits(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_window(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("unexpected at %0t: cycle %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // Restart register write, one strobe cycle
  task automatic command(input logic [7:0] code);
    @(negedge sys_clk);
    restartWrite = 1'b1;
    restartAddr = RESTART_REG;
    restartData = code;
    @(negedge sys_clk);
    restartWrite = 1'b0;
  endtask
  // Shutdown, then log when each channel drops; tick phase gives one tick of slack
  task automatic shutdown_timed();
    int          fall [11];
    logic [10:0] ph;
    fall = '{default: 0};
    command(CMD_SHUTDOWN);
    for (int k = 1; k <= 40; k++)
    begin
      @(negedge sys_clk);
      ph = {gpoOut, rail8En, railEn};
      for (int c = 0; c < 11; c++)
        if (fall[c] == 0 && ph[c] !== 1'b1) fall[c] = k;
    end
    for (int c = 0; c < 11; c++)
      // Zero delay drops on the edge after the strobe; otherwise on the delay-th tick after the load
      check_window(fall[c], (expD[c] == 0) ? 1 : (expD[c] - 1) * TICKS + 2,
                   (expD[c] == 0) ? 1 : expD[c] * TICKS + 1);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    {railForceOff, restartWrite, restartAddr, restartData, adcRefSelect, pinFuncGpo} = '0;
    {sequenceControl, errorLogEntries, dependentMask} = '0;
    fails = 0;
    tests_run = 0;
    rstn = 1'b0;
    factoryDefault = 1'b1;
    straps = 4'ha;
    sequenceMask = 12'hfff;
    for (int i = 0; i < NUM_RAILS; i++) railShutdownDelay[i] = DELAY_W'(i);
    for (int i = 0; i < NUM_GPOS; i++) gpoShutdownDelay[i] = DELAY_W'(i + 1);
    step(4);
    rstn = 1'b1;
    step(6);
    check_bits(16'({gpoOut, rail8En, railEn}), 16'h0000);
    straps = 4'h3;
    step(2);
    check_bits(16'(targetAddr), 16'({ADDR_BASE, 4'ha}));
    adcRefSelect = 1'b1;
    step(2);
    check_bits(16'(adcRefExternal_r), 16'h0001);
    adcRefSelect = 1'b0;
    step(2);
    check_bits(16'(adcRefExternal_r), 16'h0000);
    factoryDefault = 1'b0;
    command(CMD_SEQUENCE);
    step(1);
    check_bits(16'({gpoOut, rail8En, railEn}), 16'h07ff);
    check_bits(16'(sequenceRunning_r), 16'h0001);
    shutdown_timed();
    // Shared pin as output one: its own mask bit and delay apply
    pinFuncGpo = 1'b1;
    sequenceMask = 12'hf7f;
    expD[7] = 1;
    command(CMD_SEQUENCE);
    step(1);
    check_bits(16'({gpoOut, rail8En, railEn}), 16'h07ff);
    shutdown_timed();
    pinFuncGpo = 1'b0;
    sequenceMask = 12'hfff;
    dependentMask[0] = 12'h002;
    command(CMD_SEQUENCE);
    step(6);
    railForceOff[0] = 1'b1;
    step(1);
    railForceOff[0] = 1'b0;
    for (n = 0; n < 20 && underVolt[0] !== 1'b1; n++) step(1);
    check_bits(16'(railEn[1]), 16'h0001);
    for (n = 0; n < 40 && railEn[1] === 1'b1; n++) step(1);
    check_window(n, 2, TICKS + 1);
    check_bits(16'(railEn[6:2]), 16'h001f);
    dependentMask[0] = '0;
    command(CMD_SHUTDOWN);
    step(40);
    errorLogEntries = 1'b1;
    command(CMD_SEQUENCE);
    step(1);
    check_bits(16'({heldInReset_r, railEn}), 16'h0080);
    sequenceControl = 1'b1;
    step(3);
    check_bits(16'({heldInReset_r, sequenceRunning_r, railEn}), 16'h00ff);
    complete_run();
  end
endmodule // rail_shutdown_sequencer_config_tb

bind rail_shutdown_sequencer_config rail_seq_sva u_sva (.sys_clk, .rstn, .restartWrite, .restartAddr,
  .restartData, .railShutdownDelay, .sequenceMask, .adcRefSelect, .sequenceControl, .errorLogEntries,
  .rail_enable_out, .targetAddr, .adcRefExternal_r, .heldInReset_r, .sequenceRunning_r);
`default_nettype wire
